// File: include/twu_map.vh
// register map, key values and interval counts of the timed write unlock gate
`ifndef TWU_MAP_VH
`define TWU_MAP_VH

// special-function register addresses
`define TWU_ADDR_KEY 8'HC7
`define TWU_ADDR_CHIP_CTRL 8'H9F
`define TWU_ADDR_PROG_TRIG 8'HA4
`define TWU_ADDR_POWER_MON 8'HAC
`define TWU_ADDR_WATCHDOG 8'HAA

// index of each protected register inside the bank
`define TWU_IDX_CHIP_CTRL 2'H0
`define TWU_IDX_PROG_TRIG 2'H1
`define TWU_IDX_POWER_MON 2'H2
`define TWU_IDX_WATCHDOG 2'H3

// key bytes
`define TWU_KEY_FIRST 8'HAA
`define TWU_KEY_SECOND 8'H55

// reset values
`define TWU_KEY_RESET 8'H00
`define TWU_PROT_RESET 8'H00
`define TWU_RDATA_RESET 8'H00

// last elapsed machine-cycle count of each interval, which ends on the next tick; counted at a width of 3 bits
`define TWU_CNT_ZERO 3'H0
`define TWU_CNT_ONE 3'H1
`define TWU_KEY_MCYCLES 3'H3
`define TWU_WIN_MCYCLES 3'H3

`endif

// File: rtl/twu_prot_regs.v
// bank of the four write-protected special-function registers
`timescale 1ns/1ns
`include "twu_map.vh"

module twu_prot_regs #(
  parameter DATA_W = 8
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // gated write port
  input wire wr_en_i,
  input wire [1:0] wr_idx_i,
  input wire [DATA_W-1:0] wr_data_i,
  // read port, not gated
  input wire [1:0] rd_idx_i,
  output reg [DATA_W-1:0] rd_data_o,
  // register contents
  output wire [DATA_W-1:0] chip_ctrl_o,
  output wire [DATA_W-1:0] prog_trig_o,
  output wire [DATA_W-1:0] power_mon_o,
  output wire [DATA_W-1:0] watchdog_o
);

  reg [DATA_W-1:0] mem_reg [0:3];
  integer i;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (i = 0; i < 4; i = i + 1) begin
        mem_reg[i] <= `TWU_PROT_RESET;
      end
    end else if (wr_en_i) begin
      mem_reg[wr_idx_i] <= wr_data_i;
    end
  end

  always @* begin
    rd_data_o = mem_reg[rd_idx_i];
  end

  assign chip_ctrl_o = mem_reg[`TWU_IDX_CHIP_CTRL];
  assign prog_trig_o = mem_reg[`TWU_IDX_PROG_TRIG];
  assign power_mon_o = mem_reg[`TWU_IDX_POWER_MON];
  assign watchdog_o = mem_reg[`TWU_IDX_WATCHDOG];

endmodule // twu_prot_regs

// File: rtl/twu_gate.v
// timed write unlock gate on the special-function register write path
`timescale 1ns/1ns
`include "twu_map.vh"

module twu_gate #(
  parameter DATA_W = 8
) (
  // clock and reset
  input wire MCLK_I,
  input wire RST_I,
  // machine-cycle tick from core timing
  input wire MCYCLE_TICK_I,
  // special-function register access from the cpu core
  input wire [7:0] SFR_ADDR_I,
  input wire [DATA_W-1:0] SFR_WDATA_I,
  input wire SFR_WR_I,
  input wire SFR_RD_I,
  output wire SFR_HIT_O,
  output reg [DATA_W-1:0] SFR_RDATA_O,
  output reg SFR_RVALID_O,
  // protected register contents
  output wire [DATA_W-1:0] CHIP_CTRL_O,
  output wire [DATA_W-1:0] PROG_TRIG_O,
  output wire [DATA_W-1:0] POWER_MON_O,
  output wire [DATA_W-1:0] WATCHDOG_O,
  // gate status
  output wire KEY_PENDING_O,
  output wire WINDOW_OPEN_O,
  output reg PROT_WR_DROP_O
);

  // key sequence states
  localparam S_IDLE = 1'B0;
  localparam S_PENDING = 1'B1;

  // decode of a protected address: bit 2 is the hit, bits 1:0 the index
  function [2:0] prot_decode;
    input [7:0] addr;
    begin
      case (addr)
        `TWU_ADDR_CHIP_CTRL: prot_decode = {1'B1, `TWU_IDX_CHIP_CTRL};
        `TWU_ADDR_PROG_TRIG: prot_decode = {1'B1, `TWU_IDX_PROG_TRIG};
        `TWU_ADDR_POWER_MON: prot_decode = {1'B1, `TWU_IDX_POWER_MON};
        `TWU_ADDR_WATCHDOG: prot_decode = {1'B1, `TWU_IDX_WATCHDOG};
        default: prot_decode = 3'H0;
      endcase
    end
  endfunction

  // advance of an elapsed-cycle counter; bit 3 says the interval ran out
  // the counter returns to zero when the interval ends
  function [3:0] cnt_step;
    input [2:0] cnt;
    input [2:0] limit;
    begin
      if (cnt == limit) begin
        cnt_step = {1'B1, `TWU_CNT_ZERO};
      end else begin
        cnt_step = {1'B0, cnt + `TWU_CNT_ONE};
      end
    end
  endfunction

  // counters hold elapsed machine cycles, not remaining ones
  reg state_reg;
  reg state_next;
  reg [2:0] key_cnt_reg;
  reg [2:0] key_cnt_next;
  reg win_open_reg;
  reg win_open_next;
  reg [2:0] win_cnt_reg;
  reg [2:0] win_cnt_next;
  reg [DATA_W-1:0] key_reg;
  reg [DATA_W-1:0] key_next;

  // decoded access strobes
  wire [2:0] wr_dec;
  wire [2:0] rd_dec;
  wire key_wr;
  wire key_rd;
  wire prot_wr;
  wire prot_wr_ok;
  wire [3:0] key_step;
  wire [3:0] win_step;
  wire [DATA_W-1:0] prot_rdata;
  wire prot_rd;
  wire prot_wr_drop;

  assign wr_dec = prot_decode(SFR_ADDR_I);
  assign rd_dec = prot_decode(SFR_ADDR_I);
  assign key_wr = SFR_WR_I && (SFR_ADDR_I == `TWU_ADDR_KEY);
  assign key_rd = SFR_RD_I && (SFR_ADDR_I == `TWU_ADDR_KEY);
  assign prot_wr = SFR_WR_I && wr_dec[2];
  // window state before this cycle's tick: a write completing on the last tick still lands
  assign prot_wr_ok = prot_wr && win_open_reg;
  assign prot_wr_drop = prot_wr && !win_open_reg;
  assign prot_rd = SFR_RD_I && rd_dec[2];
  assign SFR_HIT_O = (SFR_ADDR_I == `TWU_ADDR_KEY) || wr_dec[2];
  assign key_step = cnt_step(key_cnt_reg, `TWU_KEY_MCYCLES);
  assign win_step = cnt_step(win_cnt_reg, `TWU_WIN_MCYCLES);
  assign KEY_PENDING_O = state_reg;
  assign WINDOW_OPEN_O = win_open_reg;

  // key sequence watch
  always @* begin
    state_next = state_reg;
    key_cnt_next = key_cnt_reg;
    key_next = key_reg;
    if (key_wr) begin
      key_next = SFR_WDATA_I;
    end
    case (state_reg)
      S_IDLE: begin
        if (key_wr && (SFR_WDATA_I == `TWU_KEY_FIRST)) begin
          state_next = S_PENDING;
          key_cnt_next = `TWU_CNT_ZERO;
        end
      end
      S_PENDING: begin
        // a repeated AAH restarts the watch instead of abandoning it
        if (key_wr) begin
          if (SFR_WDATA_I == `TWU_KEY_FIRST) begin
            key_cnt_next = `TWU_CNT_ZERO;
          end else begin
            state_next = S_IDLE;
            key_cnt_next = `TWU_CNT_ZERO;
          end
        end else if (MCYCLE_TICK_I) begin
          key_cnt_next = key_step[2:0];
          if (key_step[3]) begin
            state_next = S_IDLE;
          end
        end
      end
      default: begin
        state_next = S_IDLE;
        key_cnt_next = `TWU_CNT_ZERO;
      end
    endcase
  end

  // write window
  always @* begin
    win_open_next = win_open_reg;
    win_cnt_next = win_cnt_reg;
    // a fresh key pair while open restarts the full window
    // key writes of other values leave an open window alone
    if (key_wr && (SFR_WDATA_I == `TWU_KEY_SECOND) && (state_reg == S_PENDING)) begin
      win_open_next = 1'B1;
      win_cnt_next = `TWU_CNT_ZERO;
    end else if (win_open_reg && MCYCLE_TICK_I) begin
      win_cnt_next = win_step[2:0];
      if (win_step[3]) begin
        win_open_next = 1'B0;
      end
    end
  end

  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_reg <= S_IDLE;
      key_cnt_reg <= `TWU_CNT_ZERO;
      win_open_reg <= 1'B0;
      win_cnt_reg <= `TWU_CNT_ZERO;
      key_reg <= `TWU_KEY_RESET;
      PROT_WR_DROP_O <= 1'B0;
    end else begin
      state_reg <= state_next;
      key_cnt_reg <= key_cnt_next;
      win_open_reg <= win_open_next;
      win_cnt_reg <= win_cnt_next;
      key_reg <= key_next;
      // drop pulse tells software its protected write was lost
      PROT_WR_DROP_O <= prot_wr_drop;
    end
  end

  // read data, one cycle after the read strobe; unmapped addresses give no valid pulse
  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      SFR_RDATA_O <= `TWU_RDATA_RESET;
      SFR_RVALID_O <= 1'B0;
    end else begin
      SFR_RVALID_O <= key_rd || prot_rd;
      if (key_rd) begin
        SFR_RDATA_O <= key_reg;
      end else if (prot_rd) begin
        SFR_RDATA_O <= prot_rdata;
      end
    end
  end

  // the bank sees only writes that passed the window check
  twu_prot_regs #(
    .DATA_W(DATA_W)
  ) u_prot_regs (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .wr_en_i(prot_wr_ok),
    .wr_idx_i(wr_dec[1:0]),
    .wr_data_i(SFR_WDATA_I),
    .rd_idx_i(rd_dec[1:0]),
    .rd_data_o(prot_rdata),
    .chip_ctrl_o(CHIP_CTRL_O),
    .prog_trig_o(PROG_TRIG_O),
    .power_mon_o(POWER_MON_O),
    .watchdog_o(WATCHDOG_O)
  );

endmodule // twu_gate

// File: testbench/twu_cpu_model.sv
// machine-cycle tick source of the cpu core
`timescale 1ns/1ns
module twu_cpu_model #(
  parameter int DIV = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // tick
  output logic tick_o
);
  logic [3:0] cnt_reg;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) cnt_reg <= 4'H0;
    else cnt_reg <= tick_o ? 4'H0 : cnt_reg + 4'H1;
  end
  assign tick_o = cnt_reg == 4'(DIV - 1);
endmodule // twu_cpu_model

// File: testbench/twu_gate_sva.sv
// assertion checker of the write unlock gate
`timescale 1ns/1ns
module twu_gate_sva (
  // clock, reset, access
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic MCYCLE_TICK_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic [7:0] SFR_WDATA_I,
  input wire logic SFR_WR_I,
  input wire logic SFR_RD_I,
  // outputs
  input wire logic SFR_HIT_O,
  input wire logic SFR_RVALID_O,
  input wire logic [7:0] CHIP_CTRL_O,
  input wire logic KEY_PENDING_O,
  input wire logic WINDOW_OPEN_O,
  input wire logic PROT_WR_DROP_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  wire pa = SFR_ADDR_I == 8'H9F || SFR_ADDR_I == 8'HA4 || SFR_ADDR_I == 8'HAC || SFR_ADDR_I == 8'HAA;
  wire kw = SFR_WR_I && SFR_ADDR_I == 8'HC7;
  wire go = kw && SFR_WDATA_I == 8'H55 && KEY_PENDING_O;
  // elapsed machine cycles of the key watch and of the window
  logic [2:0] kt;
  logic [2:0] wt;
  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      kt <= 3'H0;
      wt <= 3'H0;
    end else begin
      if (kw) kt <= 3'H0;
      else if (KEY_PENDING_O && MCYCLE_TICK_I) kt <= kt + 3'H1;
      if (go) wt <= 3'H0;
      else if (WINDOW_OPEN_O && MCYCLE_TICK_I) wt <= wt + 3'H1;
    end
  end
  property p_hit; SFR_HIT_O == (pa || SFR_ADDR_I == 8'HC7); endproperty
  a_hit: assert property (p_hit) else $error("decode");
  property p_rd; SFR_RD_I && SFR_HIT_O |=> SFR_RVALID_O; endproperty
  a_rd: assert property (p_rd) else $error("no read");
  property p_pend; kw && SFR_WDATA_I == 8'HAA |=> KEY_PENDING_O; endproperty
  a_pend: assert property (p_pend) else $error("no pend");
  property p_drop_key; kw && SFR_WDATA_I != 8'HAA |=> !KEY_PENDING_O; endproperty
  a_drop_key: assert property (p_drop_key) else $error("pend kept");
  property p_open; go |=> WINDOW_OPEN_O; endproperty
  a_open: assert property (p_open) else $error("no open");
  property p_shut; !WINDOW_OPEN_O && !go |=> !WINDOW_OPEN_O; endproperty
  a_shut: assert property (p_shut) else $error("bad open");
  property p_drop; SFR_WR_I && pa && !WINDOW_OPEN_O |=> PROT_WR_DROP_O && $stable(CHIP_CTRL_O); endproperty
  a_drop: assert property (p_drop) else $error("not dropped");
  property p_land; SFR_WR_I && SFR_ADDR_I == 8'H9F && WINDOW_OPEN_O |=> CHIP_CTRL_O == $past(SFR_WDATA_I); endproperty
  a_land: assert property (p_land) else $error("not landed");
  property p_win_close; WINDOW_OPEN_O && MCYCLE_TICK_I && wt == 3'H3 && !go |=> !WINDOW_OPEN_O; endproperty
  a_win_close: assert property (p_win_close) else $error("window overstays");
  property p_win_hold; WINDOW_OPEN_O && !(MCYCLE_TICK_I && wt == 3'H3) |=> WINDOW_OPEN_O; endproperty
  a_win_hold: assert property (p_win_hold) else $error("window shut early");
  property p_key_expire; KEY_PENDING_O && MCYCLE_TICK_I && kt == 3'H3 && !kw |=> !KEY_PENDING_O; endproperty
  a_key_expire: assert property (p_key_expire) else $error("watch overstays");
  property p_key_hold; KEY_PENDING_O && !kw && !(MCYCLE_TICK_I && kt == 3'H3) |=> KEY_PENDING_O; endproperty
  a_key_hold: assert property (p_key_hold) else $error("watch lost early");
  c_open: cover property (go);
  c_drop: cover property (PROT_WR_DROP_O);
  c_rd: cover property (SFR_RVALID_O);
  c_close: cover property (WINDOW_OPEN_O ##1 !WINDOW_OPEN_O);
endmodule // twu_gate_sva
bind twu_gate twu_gate_sva u_sva (
  .MCLK_I(MCLK_I),
  .RST_I(RST_I),
  .MCYCLE_TICK_I(MCYCLE_TICK_I),
  .SFR_ADDR_I(SFR_ADDR_I),
  .SFR_WDATA_I(SFR_WDATA_I),
  .SFR_WR_I(SFR_WR_I),
  .SFR_RD_I(SFR_RD_I),
  .SFR_HIT_O(SFR_HIT_O),
  .SFR_RVALID_O(SFR_RVALID_O),
  .CHIP_CTRL_O(CHIP_CTRL_O),
  .KEY_PENDING_O(KEY_PENDING_O),
  .WINDOW_OPEN_O(WINDOW_OPEN_O),
  .PROT_WR_DROP_O(PROT_WR_DROP_O)
);

// File: testbench/tb.sv
// self-checking bench of the write unlock gate
`timescale 1ns/1ns
module tb;
  logic MCLK_I = 1'b0, RST_I = 1'b1, SFR_WR_I = 1'b0, SFR_RD_I = 1'b0;
  logic [7:0] SFR_ADDR_I = 8'H00, SFR_WDATA_I = 8'H00;
  wire MCYCLE_TICK_I, SFR_HIT_O, SFR_RVALID_O, KEY_PENDING_O, WINDOW_OPEN_O, PROT_WR_DROP_O;
  wire [7:0] SFR_RDATA_O, CHIP_CTRL_O, PROG_TRIG_O, POWER_MON_O, WATCHDOG_O;
  logic [7:0] prot [4] = '{8'H9F, 8'HA4, 8'HAC, 8'HAA};
  int bad_count = 0;
  int num_checks = 0;
  always #4 MCLK_I = ~MCLK_I;
  twu_cpu_model cpu (.clk_i(MCLK_I), .rst_i(RST_I), .tick_o(MCYCLE_TICK_I));
  twu_gate dut (
    .MCLK_I(MCLK_I),
    .RST_I(RST_I),
    .MCYCLE_TICK_I(MCYCLE_TICK_I),
    .SFR_ADDR_I(SFR_ADDR_I),
    .SFR_WDATA_I(SFR_WDATA_I),
    .SFR_WR_I(SFR_WR_I),
    .SFR_RD_I(SFR_RD_I),
    .SFR_HIT_O(SFR_HIT_O),
    .SFR_RDATA_O(SFR_RDATA_O),
    .SFR_RVALID_O(SFR_RVALID_O),
    .CHIP_CTRL_O(CHIP_CTRL_O),
    .PROG_TRIG_O(PROG_TRIG_O),
    .POWER_MON_O(POWER_MON_O),
    .WATCHDOG_O(WATCHDOG_O),
    .KEY_PENDING_O(KEY_PENDING_O),
    .WINDOW_OPEN_O(WINDOW_OPEN_O),
    .PROT_WR_DROP_O(PROT_WR_DROP_O)
  );
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge MCLK_I);
    SFR_ADDR_I <= a;
    SFR_WDATA_I <= d;
    SFR_WR_I <= 1'b1;
    @(posedge MCLK_I);
    SFR_WR_I <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a, input logic v, input logic [7:0] d);
    @(posedge MCLK_I);
    SFR_ADDR_I <= a;
    SFR_RD_I <= 1'b1;
    @(posedge MCLK_I);
    SFR_RD_I <= 1'b0;
    #1;
    chk("valid", 8'(SFR_RVALID_O), 8'(v));
    if (v) chk("rdata", SFR_RDATA_O, d);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge MCLK_I);
    bad_count++;
    summarize;
  end
  initial begin
    repeat (2) @(posedge MCLK_I);
    RST_I <= 1'b0;
    rd(8'HC7, 1'b1, 8'H00);
    wr(8'HC7, 8'HAA);
    chk("pend", 8'(KEY_PENDING_O), 8'H01);
    wr(8'HC7, 8'H55);
    chk("open", 8'(WINDOW_OPEN_O), 8'H01);
    for (int i = 0; i < 4; i++) wr(prot[i], 8'(8'H10 + i));
    chk("drop", 8'(PROT_WR_DROP_O), 8'H00);
    for (int i = 0; i < 4; i++) rd(prot[i], 1'b1, 8'(8'H10 + i));
    chk("chip", CHIP_CTRL_O, 8'H10);
    chk("trig", PROG_TRIG_O, 8'H11);
    chk("pmon", POWER_MON_O, 8'H12);
    chk("wdog", WATCHDOG_O, 8'H13);
    rd(8'HC7, 1'b1, 8'H55);
    repeat (20) @(posedge MCLK_I);
    chk("shut", 8'(WINDOW_OPEN_O), 8'H00);
    wr(8'H9F, 8'HEE);
    chk("drop", 8'(PROT_WR_DROP_O), 8'H01);
    rd(8'H9F, 1'b1, 8'H10);
    wr(8'HC7, 8'HAA);
    repeat (20) @(posedge MCLK_I);
    wr(8'HC7, 8'H55);
    chk("late", 8'(WINDOW_OPEN_O), 8'H00);
    wr(8'HA4, 8'HEE);
    chk("drop", 8'(PROT_WR_DROP_O), 8'H01);
    chk("trig", PROG_TRIG_O, 8'H11);
    wr(8'HC7, 8'HAA);
    wr(8'HC7, 8'H33);
    chk("abandon", 8'(KEY_PENDING_O), 8'H00);
    wr(8'HC7, 8'H55);
    chk("stray", 8'(WINDOW_OPEN_O), 8'H00);
    rd(8'H10, 1'b0, 8'H00);
    chk("miss", 8'(SFR_HIT_O), 8'H00);
    // key writes kept tight, as with interrupts off
    wr(8'HC7, 8'HAA);
    wr(8'HC7, 8'H55);
    chk("tight", 8'(WINDOW_OPEN_O), 8'H01);
    chk("hit", 8'(SFR_HIT_O), 8'H01);
    wr(8'HAC, 8'H5A);
    chk("pmon", POWER_MON_O, 8'H5A);
    @(posedge MCLK_I);
    RST_I <= 1'b1;
    repeat (2) @(posedge MCLK_I);
    RST_I <= 1'b0;
    #1;
    chk("rst", 8'(WINDOW_OPEN_O), 8'H00);
    chk("pmon rst", POWER_MON_O, 8'H00);
    rd(8'HAA, 1'b1, 8'H00);
    summarize;
  end
endmodule // tb
